// [mhf_filter_regs.sv]
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "mhf_defines.svh"

// Notes on behaviour
// [R1] Config word bits 31-24 read the transmit FIFO cell count, 3, read-only.
// [R2] Config word bits 23-16 read the receive FIFO cell count, 3, read-only.
// [R3] Writing 1 to soft reset bit 0 resets the MAC logic.
// [R4] Soft reset waits until receive and transmit DMA are both idle.
// [R5] Reset bit reads 1 while pending, 0 once done; software polls it.
// [R6] Low address register: byte 0 in 15-8, byte 1 in 7-0, upper zero.
// [R7] High address register: bytes 2..5 in 31-24 down to 7-0, reset zero.
// [R8] Six-bit hash: bit i is XOR of destination bits i plus multiples of six.
// [R9] Hash indexes 64-bit table; group frame accepted when the bit is set.
// [R10] First hash register holds entries 0-31, second 32-63, both read-write.
// [R11] Register bit k maps to entry k or 32+k; clear bit grants nothing.
// [R12] Address-kind and config-value bytes are constant; writes ignored.
module mhf_filter_regs (
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        RX_DMA_IDLE,
	input  wire logic        TX_DMA_IDLE,
	input  wire logic [47:0] DEST_ADDR,
	input  wire logic        DEST_VALID,
	output logic             MAC_SOFT_RESET,
	output logic             GROUP_ACCEPT,
	output logic [47:0]      STATION_ADDR
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [47:0]            station;
	logic [63:0]            hash_table;
	logic [47:0]            query_addr;
	logic                   query_hit;
	logic [5:0]             query_hash;
	logic [5:0]             frame_hash;
	logic                   frame_hit;
	logic                   reset_pending;
	logic [3:0]             apply_count;
	mhf_pkg::mhf_rst_state_t rst_state;
	mhf_pkg::mhf_rst_state_t next_rst_state;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	logic       aw_held;
	logic       w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic       do_write;
	logic       write_ok;

	assign do_write = aw_held && w_held && !S_AXI_BVALID;

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= `MHF_ZERO_WORD;
			w_strb        <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
		end else begin
			S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY;
			S_AXI_WREADY  <= !w_held && !S_AXI_WREADY;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (aw_addr)
			`MHF_OFS_BUILD_CONFIG, `MHF_OFS_SOFT_RESET, `MHF_OFS_ADDR_LOW,
			`MHF_OFS_ADDR_HIGH, `MHF_OFS_HASH_LOW, `MHF_OFS_HASH_HIGH,
			`MHF_OFS_FILTER_QUERY, `MHF_OFS_FILTER_RESULT: write_ok = 1'b1;
			default: write_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `MHF_RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= write_ok ? `MHF_RESP_OKAY : `MHF_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	// Config word has no storage, so writes to it fall away.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			station    <= 48'h0000_0000_0000;
			hash_table <= 64'h0000_0000_0000_0000;
			query_addr <= 48'h0000_0000_0000;
		end else if (do_write) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb[b]) begin
					unique case (aw_addr)
						`MHF_OFS_ADDR_LOW: begin
							if (b == 1) station[7:0] <= w_data[15:8]; // [R6]
							if (b == 0) station[15:8] <= w_data[7:0]; // [R6]
						end
						`MHF_OFS_ADDR_HIGH: station[8*(5-b) +: 8] <= w_data[8*b +: 8]; // [R7]
						`MHF_OFS_HASH_LOW:  hash_table[8*b +: 8] <= w_data[8*b +: 8]; // [R10]
						`MHF_OFS_HASH_HIGH: hash_table[32+8*b +: 8] <= w_data[8*b +: 8]; // [R10]
						`MHF_OFS_FILTER_QUERY: if (b < 2) query_addr[8*b +: 8] <= w_data[8*b +: 8];
						default: ;
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// Soft reset sequencer
	// ----------------------------------------
	logic reset_request;
	assign reset_request = do_write && aw_addr == `MHF_OFS_SOFT_RESET &&
		w_strb[0] && w_data[`MHF_SOFT_RESET_BIT]; // [R3]

	always_comb begin
		next_rst_state = rst_state;
		unique case (rst_state)
			mhf_pkg::MHF_RST_IDLE:  if (reset_request) next_rst_state = mhf_pkg::MHF_RST_WAIT;
			mhf_pkg::MHF_RST_WAIT:  if (RX_DMA_IDLE && TX_DMA_IDLE)
				next_rst_state = mhf_pkg::MHF_RST_APPLY; // [R4]
			mhf_pkg::MHF_RST_APPLY: if (apply_count == 4'h1) next_rst_state = mhf_pkg::MHF_RST_IDLE;
			default: next_rst_state = mhf_pkg::MHF_RST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			rst_state      <= mhf_pkg::MHF_RST_IDLE;
			apply_count    <= 4'h0;
			MAC_SOFT_RESET <= 1'b0;
		end else begin
			rst_state <= next_rst_state;
			if (next_rst_state == mhf_pkg::MHF_RST_APPLY && rst_state == mhf_pkg::MHF_RST_WAIT)
				apply_count <= `MHF_MAC_RESET_CYCLES;
			else if (apply_count != 4'h0)
				apply_count <= apply_count - 4'h1;
			MAC_SOFT_RESET <= next_rst_state == mhf_pkg::MHF_RST_APPLY; // [R3]
		end
	end
	assign reset_pending = rst_state != mhf_pkg::MHF_RST_IDLE; // [R5]

	// ----------------------------------------
	// Hash lookups
	// ----------------------------------------
	mhf_hash_fold u_frame_fold (
		.dest_addr  (DEST_ADDR),
		.table_bits (hash_table),
		.hash       (frame_hash),
		.hit        (frame_hit)
	);
	mhf_hash_fold u_query_fold (
		.dest_addr  ({query_addr[47:16], query_addr[15:0]}),
		.table_bits (hash_table),
		.hash       (query_hash),
		.hit        (query_hit)
	);

	// Only group addresses (first-byte low bit set) may use the hash path.
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			GROUP_ACCEPT <= 1'b0;
			STATION_ADDR <= 48'h0000_0000_0000;
		end else begin
			GROUP_ACCEPT <= DEST_VALID && DEST_ADDR[0] && frame_hit; // [R9]
			STATION_ADDR <= station;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic [31:0] rd_word;
	logic        rd_ok;
	always_comb begin
		rd_word = `MHF_ZERO_WORD;
		rd_ok   = 1'b1;
		unique case (S_AXI_ARADDR)
			`MHF_OFS_BUILD_CONFIG: rd_word = {`MHF_TX_CELL_COUNT, `MHF_RX_CELL_COUNT,
				`MHF_ADDR_KIND_CODE, `MHF_CFG_VALUE}; // [R1] [R2] [R12]
			`MHF_OFS_SOFT_RESET:   rd_word = {31'h0, reset_pending}; // [R5]
			`MHF_OFS_ADDR_LOW:     rd_word = {16'h0, station[7:0], station[15:8]}; // [R6]
			`MHF_OFS_ADDR_HIGH:    rd_word = {station[23:16], station[31:24],
				station[39:32], station[47:40]}; // [R7]
			`MHF_OFS_HASH_LOW:     rd_word = hash_table[31:0]; // [R10]
			`MHF_OFS_HASH_HIGH:    rd_word = hash_table[63:32]; // [R10]
			`MHF_OFS_FILTER_QUERY: rd_word = {16'h0, query_addr[15:0]};
			`MHF_OFS_FILTER_RESULT: rd_word = {24'h0, query_hit, 1'b0, query_hash};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= `MHF_ZERO_WORD;
			S_AXI_RRESP   <= `MHF_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_ARVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_word;
				S_AXI_RRESP  <= rd_ok ? `MHF_RESP_OKAY : `MHF_RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_cfg_read;
		@(posedge CORE_CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `MHF_OFS_BUILD_CONFIG
		|=> S_AXI_RDATA == 32'h0303_0101;
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config word wrong"); // [R1]
	property p_cfg_rx;
		@(posedge CORE_CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `MHF_OFS_BUILD_CONFIG
		|=> S_AXI_RDATA[23:16] == 8'h03;
	endproperty
	a_cfg_rx: assert property (p_cfg_rx) else $error("rx cell count wrong"); // [R2]
	property p_reset_waits;
		@(posedge CORE_CLK) disable iff (RESET)
		MAC_SOFT_RESET && !$past(MAC_SOFT_RESET) |-> $past(RX_DMA_IDLE && TX_DMA_IDLE);
	endproperty
	a_reset_waits: assert property (p_reset_waits) else $error("reset while DMA busy"); // [R4]
	property p_reset_len;
		@(posedge CORE_CLK) disable iff (RESET)
		$rose(MAC_SOFT_RESET) |-> MAC_SOFT_RESET [*4] ##1 !MAC_SOFT_RESET;
	endproperty
	a_reset_len: assert property (p_reset_len) else $error("reset pulse length"); // [R3]
	property p_pending_bit;
		@(posedge CORE_CLK) disable iff (RESET)
		reset_request && rst_state == mhf_pkg::MHF_RST_IDLE |=> reset_pending;
	endproperty
	a_pending_bit: assert property (p_pending_bit) else $error("pending not shown"); // [R5]
	property p_low_reserved;
		@(posedge CORE_CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `MHF_OFS_ADDR_LOW
		|=> S_AXI_RDATA[31:16] == 16'h0000 && S_AXI_RDATA[15:8] == station[7:0];
	endproperty
	a_low_reserved: assert property (p_low_reserved) else $error("low addr read"); // [R6]
	property p_high_layout;
		@(posedge CORE_CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `MHF_OFS_ADDR_HIGH
		|=> S_AXI_RDATA[7:0] == station[47:40] && S_AXI_RDATA[31:24] == station[23:16];
	endproperty
	a_high_layout: assert property (p_high_layout) else $error("high addr read"); // [R7]
	property p_hash_fold;
		@(posedge CORE_CLK) disable iff (RESET)
		frame_hash[0] == ^{DEST_ADDR[42], DEST_ADDR[36], DEST_ADDR[30], DEST_ADDR[24],
			DEST_ADDR[18], DEST_ADDR[12], DEST_ADDR[6], DEST_ADDR[0]};
	endproperty
	a_hash_fold: assert property (p_hash_fold) else $error("hash bit 0 wrong"); // [R8]
	property p_accept;
		@(posedge CORE_CLK) disable iff (RESET)
		DEST_VALID && DEST_ADDR[0] |=> GROUP_ACCEPT == $past(hash_table[frame_hash]);
	endproperty
	a_accept: assert property (p_accept) else $error("group accept wrong"); // [R9] [R11]
	property p_hash_high;
		@(posedge CORE_CLK) disable iff (RESET)
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `MHF_OFS_HASH_HIGH
		|=> S_AXI_RDATA == hash_table[63:32];
	endproperty
	a_hash_high: assert property (p_hash_high) else $error("hash high read"); // [R10]
	c_soft_reset: cover property (@(posedge CORE_CLK) disable iff (RESET)
		rst_state == mhf_pkg::MHF_RST_WAIT ##1 rst_state == mhf_pkg::MHF_RST_APPLY);
	c_accept: cover property (@(posedge CORE_CLK) disable iff (RESET) GROUP_ACCEPT);
	c_write: cover property (@(posedge CORE_CLK) disable iff (RESET) do_write && write_ok);
endmodule : mhf_filter_regs

// [mhf_defines.svh]
`ifndef MHF_DEFINES_SVH
`define MHF_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MHF_OFS_BUILD_CONFIG  8'h00
`define MHF_OFS_SOFT_RESET    8'h04
`define MHF_OFS_ADDR_LOW      8'h08
`define MHF_OFS_ADDR_HIGH     8'h0C
`define MHF_OFS_HASH_LOW      8'h10
`define MHF_OFS_HASH_HIGH     8'h14
`define MHF_OFS_FILTER_QUERY  8'h18
`define MHF_OFS_FILTER_RESULT 8'h1C

// ----------------------------------------
// Build configuration fields
// ----------------------------------------
`define MHF_TX_CELL_COUNT     8'h03
`define MHF_RX_CELL_COUNT     8'h03
`define MHF_ADDR_KIND_CODE    8'h01
`define MHF_CFG_VALUE         8'h01
`define MHF_SOFT_RESET_BIT    0

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define MHF_ZERO_WORD         32'h0000_0000
`define MHF_RESP_OKAY         2'h0
`define MHF_RESP_SLVERR       2'h2
`define MHF_HASH_WIDTH        6
`define MHF_MAC_RESET_CYCLES  4'h4

`endif

// [mhf_pkg.sv]
package mhf_pkg;
	typedef enum logic [1:0] {
		MHF_RST_IDLE  = 2'h0,
		MHF_RST_WAIT  = 2'h1,
		MHF_RST_APPLY = 2'h3
	} mhf_rst_state_t;
endpackage : mhf_pkg

// [mhf_hash_fold.sv]
`timescale 1ns/10ps
`include "mhf_defines.svh"

// Folds a destination address into a table index and looks the entry up.
module mhf_hash_fold #(
	parameter int ADDR_W = 48,
	parameter int HASH_W = `MHF_HASH_WIDTH
) (
	input  wire logic [ADDR_W-1:0]      dest_addr,
	input  wire logic [(1<<HASH_W)-1:0] table_bits,
	output logic      [HASH_W-1:0]      hash,
	output logic                        hit
);
	always_comb begin
		hash = '0;
		for (int k = 0; k < ADDR_W; k++) begin
			hash[k % HASH_W] = hash[k % HASH_W] ^ dest_addr[k]; // [R8]
		end
		hit = table_bits[hash]; // [R9] [R11]
	end
endmodule : mhf_hash_fold

// [tb_top.sv]
`timescale 1ns/10ps
`include "mhf_defines.svh"

`define TB_CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
	logic        clk, rst, awv, wv, bready, arv, rready, rx_idle, tx_idle, dest_v;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic        awready, wready, bvalid, arready, rvalid, soft_rst, accept;
	logic [47:0] dest, station;
	int          fail_count, checks_done, cycles;

	mhf_filter_regs i_mhf_filter_regs (.CORE_CLK(clk), .RESET(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.RX_DMA_IDLE(rx_idle), .TX_DMA_IDLE(tx_idle), .DEST_ADDR(dest), .DEST_VALID(dest_v),
		.MAC_SOFT_RESET(soft_rst), .GROUP_ACCEPT(accept), .STATION_ADDR(station));

	// ----------------------------------------
	// Clock, watchdog, verdict
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic close_out;
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// Whole run needs a few hundred cycles; generous ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end

	// ----------------------------------------
	// Bus master tasks
	// ----------------------------------------
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		logic done;
		@(posedge clk);
		awaddr <= a; awv <= 1'b1; wdata <= d; wstrb <= s; wv <= 1'b1; bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			if (awv && awready === 1'b1) awv <= 1'b0;
			if (wv && wready === 1'b1) wv <= 1'b0;
			if (bvalid === 1'b1) begin
				rs = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a);
		logic done;
		@(posedge clk);
		araddr <= a; arv <= 1'b1; rready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			if (arv && arready === 1'b1) arv <= 1'b0;
			if (rvalid === 1'b1) begin
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : bus_read

	function automatic logic [5:0] fold(input logic [47:0] a);
		logic [5:0] h;
		h = 6'h00;
		for (int k = 0; k < 8; k++) h ^= a[k*6 +: 6];
		return h;
	endfunction : fold

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_config;
		bus_read(`MHF_OFS_BUILD_CONFIG);
		`TB_CHK("config", 32'h0303_0101, rd)
		bus_write(`MHF_OFS_BUILD_CONFIG, 32'hFFFF_FFFF);
		`TB_CHK("config write resp", `MHF_RESP_OKAY, rs)
		bus_read(`MHF_OFS_BUILD_CONFIG);
		`TB_CHK("config after write", 32'h0303_0101, rd)
		bus_write(8'h20, 32'hFFFF_FFFF);
		`TB_CHK("unmapped write resp", `MHF_RESP_SLVERR, rs)
		bus_read(8'h20);
		`TB_CHK("unmapped resp", `MHF_RESP_SLVERR, rs)
		`TB_CHK("unmapped data", 32'h0000_0000, rd)
	endtask : t_config

	task automatic t_station;
		bus_read(`MHF_OFS_ADDR_HIGH);
		`TB_CHK("addr high reset", 32'h0000_0000, rd)
		bus_write(`MHF_OFS_ADDR_LOW, 32'hFFFF_A1B2);
		bus_write(`MHF_OFS_ADDR_HIGH, 32'hC3D4_E5F6);
		bus_read(`MHF_OFS_ADDR_LOW);
		`TB_CHK("addr low", 32'h0000_A1B2, rd)
		bus_read(`MHF_OFS_ADDR_HIGH);
		`TB_CHK("addr high", 32'hC3D4_E5F6, rd)
		`TB_CHK("station", 48'hF6E5_D4C3_B2A1, station)
		// Only lane 1 enabled: byte 4 changes, the rest must survive
		bus_write(`MHF_OFS_ADDR_HIGH, 32'h1111_1111, 4'h2);
		bus_read(`MHF_OFS_ADDR_HIGH);
		`TB_CHK("addr high strobe", 32'hC3D4_11F6, rd)
		`TB_CHK("station strobe", 48'hF611_D4C3_B2A1, station)
	endtask : t_station

	task automatic probe(input logic [47:0] a, input logic [63:0] tbl, input logic exp);
		bus_write(`MHF_OFS_HASH_LOW, tbl[31:0]);
		bus_write(`MHF_OFS_HASH_HIGH, tbl[63:32]);
		bus_read(`MHF_OFS_HASH_HIGH);
		`TB_CHK("hash high", tbl[63:32], rd)
		bus_read(`MHF_OFS_HASH_LOW);
		`TB_CHK("hash low", tbl[31:0], rd)
		@(posedge clk);
		dest <= a; dest_v <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`TB_CHK("accept", exp, accept)
		@(posedge clk);
		dest_v <= 1'b0;
	endtask : probe

	task automatic t_hash;
		logic [47:0] addrs [4];
		logic [63:0] one;
		addrs = '{48'h0000_0000_0001, 48'h8000_0000_0001, 48'hFFFF_FFFF_FFFF, 48'h0123_4567_89AB};
		foreach (addrs[j]) begin
			one = 64'h1 << fold(addrs[j]);
			probe(addrs[j], one, 1'b1);
			probe(addrs[j], ~one, 1'b0);
		end
		probe(48'h0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
		// Query path with the table still all ones
		bus_write(`MHF_OFS_FILTER_QUERY, 32'hFFFF_ABCD);
		bus_read(`MHF_OFS_FILTER_QUERY);
		`TB_CHK("query addr", 32'h0000_ABCD, rd)
		bus_read(`MHF_OFS_FILTER_RESULT);
		`TB_CHK("query result", {24'h0, 1'b1, 1'b0, fold(48'h0000_0000_ABCD)}, rd)
	endtask : t_hash

	// Samples the registered pulse at each edge, before it updates
	task automatic count_pulses(input int n, inout int pulses);
		repeat (n) begin
			@(posedge clk);
			if (soft_rst === 1'b1) pulses++;
		end
	endtask : count_pulses

	task automatic t_soft_reset;
		int pulses;
		rx_idle <= 1'b0;
		tx_idle <= 1'b1;
		bus_write(`MHF_OFS_SOFT_RESET, 32'h0000_0001);
		bus_read(`MHF_OFS_SOFT_RESET);
		`TB_CHK("reset pending", 32'h0000_0001, rd)
		pulses = 0;
		count_pulses(10, pulses);
		rx_idle <= 1'b1;
		tx_idle <= 1'b0;
		count_pulses(10, pulses);
		`TB_CHK("reset held off", 0, pulses)
		tx_idle <= 1'b1;
		count_pulses(30, pulses);
		`TB_CHK("reset pulse cycles", 4, pulses)
		bus_read(`MHF_OFS_SOFT_RESET);
		`TB_CHK("reset done", 32'h0000_0000, rd)
	endtask : t_soft_reset

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0; rready = 1'b0;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h0;
		rx_idle = 1'b1; tx_idle = 1'b1; dest = 48'h0000_0000_0000; dest_v = 1'b0;
		fail_count = 0; checks_done = 0; cycles = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_config();
		t_station();
		t_hash();
		t_soft_reset();
		close_out();
	end
endmodule : tb_top
